// File: adcc_cfg_top.sv
// reset, power and serial protocol configuration registers
`timescale 1ns/1ps
module adcc_cfg_top (
  // system clock and power-on reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // reset pin
  input wire logic reset_pin_n,
  // serial configuration link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  // converter status
  input wire logic convert_start_select,
  input wire logic conversion_done,
  input wire logic supply_alarm_raw,
  input wire logic input_alarm_raw,
  // converter controls
  output logic supply_alarm,
  output logic input_alarm,
  output logic light_sleep_state,
  output logic power_down,
  output logic link_cpol,
  output logic link_cpha,
  // output protocol controls
  output logic src_sync_mode,
  output logic sync_clock_internal,
  output logic out_mode_invalid,
  output logic dual_data_lane,
  // shared alarm, data and general output pin
  output logic shared_alarm_data_pin_o,
  output logic shared_alarm_data_pin_oe
);

  // synchronisers
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic rpin_s1_reg;
  logic rpin_s2_reg;
  logic tog_a_s1_reg;
  logic tog_a_s2_reg;
  logic tog_a_s3_reg;
  logic tog_b_s1_reg;
  logic tog_b_s2_reg;
  logic tog_b_s3_reg;

  // link instances, one per clock edge
  adcc_pkg::adcc_frame_t word_a;
  adcc_pkg::adcc_frame_t word_b;
  logic tog_a;
  logic tog_b;
  logic sdo_a;
  logic sdo_b;
  logic [7:0] rd_byte_reg;
  logic [7:0] rd_byte_next;
  wire sclk_inv = ~sclk;

  // register fields
  logic [7:0] key_reg;
  logic [7:0] key_next;
  logic sup_dis_reg;
  logic sup_dis_next;
  logic in_dis_reg;
  logic in_dis_next;
  logic class_reg;
  logic class_next;
  logic nap_reg;
  logic nap_next;
  logic power_down_request_reg;
  logic power_down_request_next;
  logic [1:0] in_prot_reg;
  logic [1:0] in_prot_next;
  logic gpo_reg;
  logic gpo_next;
  logic [1:0] dual_reg;
  logic [1:0] dual_next;
  logic sync_clk_reg;
  logic sync_clk_next;
  logic [1:0] out_mode_reg;
  logic [1:0] out_mode_next;

  // phase 0 needs each bit out before its sampling edge
  wire launch_lead = ~in_prot_reg[0];

  adcc_link u_link_rise (
    .sclk(sclk),
    .cs_n(cs_n),
    .sdi(sdi),
    .rst_n(rst_n),
    .launch_lead(launch_lead),
    .rd_byte(rd_byte_reg),
    .frame_word(word_a),
    .frame_toggle(tog_a),
    .sdo(sdo_a)
  );

  adcc_link u_link_fall (
    .sclk(sclk_inv),
    .cs_n(cs_n),
    .sdi(sdi),
    .rst_n(rst_n),
    .launch_lead(launch_lead),
    .rd_byte(rd_byte_reg),
    .frame_word(word_b),
    .frame_toggle(tog_b),
    .sdo(sdo_b)
  );

  always_ff @(posedge clk_sys)
  begin
    cs_s1_reg <= convert_start_select;
    cs_s2_reg <= cs_s1_reg;
    rpin_s1_reg <= reset_pin_n;
    rpin_s2_reg <= rpin_s1_reg;
  end

  // frame events, cleared with the link so no false event follows reset
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tog_a_s1_reg <= 1'b0;
      tog_a_s2_reg <= 1'b0;
      tog_a_s3_reg <= 1'b0;
      tog_b_s1_reg <= 1'b0;
      tog_b_s2_reg <= 1'b0;
      tog_b_s3_reg <= 1'b0;
    end
    else
    begin
      tog_a_s1_reg <= tog_a;
      tog_a_s2_reg <= tog_a_s1_reg;
      tog_a_s3_reg <= tog_a_s2_reg;
      tog_b_s1_reg <= tog_b;
      tog_b_s2_reg <= tog_b_s1_reg;
      tog_b_s3_reg <= tog_b_s2_reg;
    end
  end

  // sample edge chosen by polarity and phase
  wire sample_rise = (in_prot_reg[1] == in_prot_reg[0]);
  wire new_a = tog_a_s2_reg ^ tog_a_s3_reg;
  wire new_b = tog_b_s2_reg ^ tog_b_s3_reg;
  wire frame_valid = sample_rise ? new_a : new_b;
  adcc_pkg::adcc_frame_t frm;
  assign frm = sample_rise ? word_a : word_b;

  // reset classes
  wire pin_low = ~rpin_s2_reg;
  wire por_clr = ~rst_n | (pin_low & ~class_reg);
  wire app_clr = pin_low & class_reg;
  wire any_clr = por_clr | app_clr;

  // write decode per byte address
  wire is_wr = frame_valid && (frm.cmd == adcc_pkg::CMD_WRITE);
  wire is_rd = frame_valid && (frm.cmd == adcc_pkg::CMD_READ);
  wire key_open = (key_reg == adcc_pkg::UNLOCK_VALUE);
  wire wr_key = is_wr && (frm.addr == adcc_pkg::ADDR_RST_PWR_B1);
  wire wr_rp_lo = is_wr && (frm.addr == adcc_pkg::ADDR_RST_PWR_B0) && key_open;
  wire wr_in = is_wr && (frm.addr == adcc_pkg::ADDR_IN_PROT_B0);
  wire wr_out_lo = is_wr && (frm.addr == adcc_pkg::ADDR_OUT_CTL_B0);
  wire wr_out_hi = is_wr && (frm.addr == adcc_pkg::ADDR_OUT_CTL_B1);
  wire [7:0] d = frm.data;

  // next values
  assign key_next = wr_key ? d : key_reg;
  assign sup_dis_next = wr_rp_lo ? d[adcc_pkg::SUP_AL_BIT] : sup_dis_reg;
  assign in_dis_next = wr_rp_lo ? d[adcc_pkg::IN_AL_BIT] : in_dis_reg;
  // once set, the class bit only clears on power-on
  assign class_next = class_reg | (wr_rp_lo & d[adcc_pkg::CLASS_BIT]);
  assign nap_next = wr_rp_lo ? d[adcc_pkg::NAP_BIT] : nap_reg;
  assign power_down_request_next = wr_rp_lo ? d[adcc_pkg::POWER_DOWN_REQUEST_BIT] : power_down_request_reg;
  assign in_prot_next = wr_in ? d[1:0] : in_prot_reg;
  assign gpo_next = wr_out_hi ? d[adcc_pkg::GPO_BIT - 8] : gpo_reg;
  assign dual_next = wr_out_hi ? d[adcc_pkg::DUAL_LSB - 8 +: 2] : dual_reg;
  assign sync_clk_next = wr_out_lo ? d[adcc_pkg::SYNC_CLK_BIT] : sync_clk_reg;
  assign out_mode_next = wr_out_lo ? d[adcc_pkg::OUT_MODE_LSB +: 2] : out_mode_reg;

  // fields cleared by either reset
  always_ff @(posedge clk_sys)
  begin
    if (any_clr)
    begin
      key_reg <= adcc_pkg::KEY_RESET;
      sup_dis_reg <= adcc_pkg::FLAG_RESET;
      in_dis_reg <= adcc_pkg::FLAG_RESET;
      power_down_request_reg <= adcc_pkg::FLAG_RESET;
      gpo_reg <= adcc_pkg::FLAG_RESET;
      dual_reg <= adcc_pkg::FIELD2_RESET;
    end
    else
    begin
      key_reg <= key_next;
      sup_dis_reg <= sup_dis_next;
      in_dis_reg <= in_dis_next;
      power_down_request_reg <= power_down_request_next;
      gpo_reg <= gpo_next;
      dual_reg <= dual_next;
    end
  end

  // fields cleared by power-on class reset only
  always_ff @(posedge clk_sys)
  begin
    if (por_clr)
    begin
      class_reg <= adcc_pkg::FLAG_RESET;
      nap_reg <= adcc_pkg::FLAG_RESET;
      in_prot_reg <= adcc_pkg::FIELD2_RESET;
      sync_clk_reg <= adcc_pkg::FLAG_RESET;
      out_mode_reg <= adcc_pkg::FIELD2_RESET;
    end
    else
    begin
      class_reg <= class_next;
      nap_reg <= nap_next;
      in_prot_reg <= in_prot_next;
      sync_clk_reg <= sync_clk_next;
      out_mode_reg <= out_mode_next;
    end
  end

  // read-back words, reserved bits zero
  wire [31:0] rp_word = {16'h0000, key_reg, 2'h0, sup_dis_reg, in_dis_reg, 1'b0,
                         class_reg, nap_reg, power_down_request_reg};
  wire [31:0] in_word = {30'h00000000, in_prot_reg};
  wire [31:0] out_word = {19'h00000, gpo_reg, 2'h0, dual_reg, 1'b0, sync_clk_reg,
                          4'h0, out_mode_reg};
  wire [5:0] rd_word_idx = frm.addr[7:2];
  wire [1:0] rd_lane = frm.addr[1:0];
  logic [31:0] rd_word;

  always_comb
  begin
    case (rd_word_idx)
      adcc_pkg::WORD_RST_PWR: rd_word = rp_word;
      adcc_pkg::WORD_IN_PROT: rd_word = in_word;
      adcc_pkg::WORD_OUT_CTL: rd_word = out_word;
      default: rd_word = 32'h00000000;
    endcase
  end

  assign rd_byte_next = is_rd ? rd_word[{rd_lane, 3'h0} +: 8] : rd_byte_reg;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      rd_byte_reg <= 8'h00;
    else
      rd_byte_reg <= rd_byte_next;
  end

  // converter control outputs
  wire nap_go = nap_reg & cs_s2_reg & conversion_done & ~power_down_request_reg;
  wire src_mode = (out_mode_reg == adcc_pkg::OUT_MODE_SRC_SYNC);
  logic pin_o_next;
  logic pin_oe_next;

  always_comb
  begin
    case (dual_reg)
      adcc_pkg::PIN_TRISTATE:
      begin
        pin_o_next = 1'b0;
        pin_oe_next = 1'b0;
      end
      adcc_pkg::PIN_ALARM:
      begin
        pin_o_next = (supply_alarm_raw & ~sup_dis_reg) | (input_alarm_raw & ~in_dis_reg);
        pin_oe_next = 1'b1;
      end
      adcc_pkg::PIN_GPO:
      begin
        pin_o_next = gpo_reg;
        pin_oe_next = 1'b1;
      end
      adcc_pkg::PIN_DUAL_DATA:
      begin
        pin_o_next = 1'b0;
        pin_oe_next = 1'b1;
      end
      default:
      begin
        pin_o_next = 1'b0;
        pin_oe_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      supply_alarm <= 1'b0;
      input_alarm <= 1'b0;
      light_sleep_state <= 1'b0;
      power_down <= 1'b0;
      link_cpol <= 1'b0;
      link_cpha <= 1'b0;
      src_sync_mode <= 1'b0;
      sync_clock_internal <= 1'b0;
      out_mode_invalid <= 1'b0;
      dual_data_lane <= 1'b0;
      shared_alarm_data_pin_o <= 1'b0;
      shared_alarm_data_pin_oe <= 1'b0;
    end
    else
    begin
      supply_alarm <= supply_alarm_raw & ~sup_dis_reg;
      input_alarm <= input_alarm_raw & ~in_dis_reg;
      light_sleep_state <= nap_go;
      power_down <= power_down_request_reg;
      link_cpol <= in_prot_reg[1];
      link_cpha <= in_prot_reg[0];
      src_sync_mode <= src_mode;
      sync_clock_internal <= src_mode & sync_clk_reg;
      out_mode_invalid <= (out_mode_reg == adcc_pkg::OUT_MODE_INVALID);
      dual_data_lane <= (dual_reg == adcc_pkg::PIN_DUAL_DATA);
      shared_alarm_data_pin_o <= pin_o_next;
      shared_alarm_data_pin_oe <= pin_oe_next;
    end
  end

  // data launched on the edge opposite to sampling
  assign sdo = sample_rise ? sdo_b : sdo_a;

endmodule : adcc_cfg_top

// File: adcc_pkg.sv
// constants and types shared by the converter configuration block
package adcc_pkg;

  // byte addresses of the register group
  localparam logic [7:0] ADDR_RST_PWR_B0 = 8'h04;
  localparam logic [7:0] ADDR_RST_PWR_B1 = 8'h05;
  localparam logic [7:0] ADDR_IN_PROT_B0 = 8'h08;
  localparam logic [7:0] ADDR_OUT_CTL_B0 = 8'h0C;
  localparam logic [7:0] ADDR_OUT_CTL_B1 = 8'h0D;
  localparam logic [5:0] WORD_RST_PWR = 6'h01;
  localparam logic [5:0] WORD_IN_PROT = 6'h02;
  localparam logic [5:0] WORD_OUT_CTL = 6'h03;

  // unlock value of the write key
  localparam logic [7:0] UNLOCK_VALUE = 8'h69;

  // serial frame commands
  localparam logic [7:0] CMD_WRITE = 8'hD0;
  localparam logic [7:0] CMD_READ = 8'hC8;
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam logic [4:0] READ_FIRST = 5'h08;
  localparam logic [4:0] READ_LAST = 5'h0F;

  // field positions, reset/power register
  localparam int KEY_LSB = 8;
  localparam int SUP_AL_BIT = 5;
  localparam int IN_AL_BIT = 4;
  localparam int CLASS_BIT = 2;
  localparam int NAP_BIT = 1;
  localparam int POWER_DOWN_REQUEST_BIT = 0;

  // field positions, output control register
  localparam int GPO_BIT = 12;
  localparam int DUAL_LSB = 8;
  localparam int SYNC_CLK_BIT = 6;
  localparam int OUT_MODE_LSB = 0;

  // field codes
  localparam logic [1:0] PIN_TRISTATE = 2'h0;
  localparam logic [1:0] PIN_ALARM = 2'h1;
  localparam logic [1:0] PIN_GPO = 2'h2;
  localparam logic [1:0] PIN_DUAL_DATA = 2'h3;
  localparam logic [1:0] OUT_MODE_INVALID = 2'h2;
  localparam logic [1:0] OUT_MODE_SRC_SYNC = 2'h3;

  // values after reset
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [1:0] FIELD2_RESET = 2'h0;
  localparam logic FLAG_RESET = 1'b0;

  // one received serial frame
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] addr;
    logic [7:0] data;
  } adcc_frame_t;

endpackage : adcc_pkg

// File: adcc_link.sv
// serial link shifter clocked by the link clock
`timescale 1ns/1ps
module adcc_link (
  // link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  // reset from the system side
  input wire logic rst_n,
  // launch one slot early when sampling on the leading edge
  input wire logic launch_lead,
  // read byte from the system side, quasi-static
  input wire logic [7:0] rd_byte,
  // frame to the system side
  output adcc_pkg::adcc_frame_t frame_word,
  output logic frame_toggle,
  output logic sdo
);

  logic [4:0] cnt_reg;
  logic [22:0] shift_reg;
  logic [4:0] rd_idx;
  logic [4:0] launch_slot;
  wire frame_end = (cnt_reg == adcc_pkg::FRAME_LAST);
  wire in_read = (launch_slot >= adcc_pkg::READ_FIRST) && (launch_slot <= adcc_pkg::READ_LAST);

  assign launch_slot = cnt_reg + {4'h0, launch_lead};
  assign rd_idx = adcc_pkg::READ_LAST - launch_slot;

  // bit counter cleared by the frame select
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      cnt_reg <= 5'h00;
    else if (!frame_end)
      cnt_reg <= cnt_reg + 5'h01;
  end

  always_ff @(posedge sclk)
  begin
    shift_reg <= {shift_reg[21:0], sdi};
  end

  // completed frame and its event toggle
  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_word <= '0;
      frame_toggle <= 1'b0;
    end
    else if (!cs_n && frame_end)
    begin
      frame_word <= {shift_reg, sdi};
      frame_toggle <= ~frame_toggle;
    end
  end

  // read byte shifted out msb first
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      sdo <= 1'b0;
    else if (in_read)
      sdo <= rd_byte[rd_idx[2:0]];
    else
      sdo <= 1'b0;
  end

endmodule : adcc_link

// File: adcc_cfg_monitor.sv
// port assertions for the configuration block
`timescale 1ns/1ps
module adcc_cfg_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // status inputs
  input wire logic convert_start_select,
  input wire logic conversion_done,
  input wire logic supply_alarm_raw,
  input wire logic input_alarm_raw,
  // controls
  input wire logic supply_alarm,
  input wire logic input_alarm,
  input wire logic light_sleep_state,
  input wire logic power_down,
  input wire logic src_sync_mode,
  input wire logic sync_clock_internal,
  input wire logic out_mode_invalid,
  input wire logic dual_data_lane,
  input wire logic shared_alarm_data_pin_o,
  input wire logic shared_alarm_data_pin_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sup_alarm_gate_a: assert property (!supply_alarm_raw |=> !supply_alarm)
    else $error("supply alarm without cause");
  in_alarm_gate_a: assert property (!input_alarm_raw |=> !input_alarm)
    else $error("input alarm without cause");
  nap_done_a: assert property (!conversion_done |=> !light_sleep_state)
    else $error("nap while converting");
  nap_select_a: assert property (!convert_start_select [*4] |=> !light_sleep_state)
    else $error("nap with select low");
  nap_power_down_request_a: assert property (light_sleep_state |-> !power_down)
    else $error("nap during power-down");
  mode_excl_a: assert property (!(src_sync_mode && out_mode_invalid))
    else $error("two output modes at once");
  sync_clk_a: assert property (sync_clock_internal |-> src_sync_mode)
    else $error("clock source outside sync mode");
  dual_pin_a: assert property (dual_data_lane |-> shared_alarm_data_pin_oe)
    else $error("dual lane pin not driven");
  cover property ($rose(light_sleep_state));
  cover property (src_sync_mode && sync_clock_internal);
  cover property (dual_data_lane);
  cover property (power_down);
endmodule : adcc_cfg_monitor

bind adcc_cfg_top adcc_cfg_monitor adcc_cfg_monitor_inst (.clk_sys, .rst_n, .convert_start_select,
  .conversion_done, .supply_alarm_raw, .input_alarm_raw, .supply_alarm, .input_alarm,
  .light_sleep_state, .power_down, .src_sync_mode, .sync_clock_internal,
  .out_mode_invalid, .dual_data_lane, .shared_alarm_data_pin_o, .shared_alarm_data_pin_oe);

// File: adcc_host_model.sv
// host controller model on the serial link
`timescale 1ns/1ps
module adcc_host_model (
  // link pins
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  logic cpol = 1'h0;
  logic cpha = 1'h0;
  logic [7:0] rd;
  initial
  begin
    sclk = 1'h0;
    cs_n = 1'h1;
    sdi = 1'h0;
  end
  // one 24-bit frame msb first, read byte caught in slots 8..15
  task automatic xfer(input logic [23:0] f);
    int k;
    sclk = cpol;
    #1.3;
    cs_n = 1'h0;
    for (k = 23; k >= 0; k--)
    begin
      if (!cpha) sdi = f[k];
      #3 sclk = ~sclk;
      if (!cpha && k < 16 && k > 7) rd[k - 8] = sdo;
      if (cpha) sdi = f[k];
      #3 sclk = ~sclk;
      if (cpha && k < 16 && k > 7) rd[k - 8] = sdo;
    end
    #3 cs_n = 1'h1;
    sdi = ~sdi;
  endtask : xfer
endmodule : adcc_host_model

// File: adcc_cfg_tb_top.sv
// self-checking bench for the configuration block
`timescale 1ns/1ps
module adcc_cfg_tb_top;
  logic clk_sys, rst_n, reset_pin_n, conversion_done, supply_alarm_raw, input_alarm_raw;
  logic sclk, cs_n, sdi, sdo, supply_alarm, input_alarm, light_sleep_state, power_down;
  logic link_cpol, link_cpha, src_sync_mode, sync_clock_internal, out_mode_invalid;
  logic dual_data_lane, shared_alarm_data_pin_o, shared_alarm_data_pin_oe;
  logic [7:0] obs;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h4C;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int i;
  event res_evt;
  wire logic [7:0] ctl_a = {2'h0, supply_alarm, input_alarm, light_sleep_state, power_down,
    link_cpol, link_cpha};
  wire logic [7:0] ctl_b = {2'h0, src_sync_mode, sync_clock_internal, out_mode_invalid,
    dual_data_lane, shared_alarm_data_pin_o, shared_alarm_data_pin_oe};
  adcc_host_model adcc_host_model_inst (.sclk, .cs_n, .sdi, .sdo);
  adcc_cfg_top adcc_cfg_top_inst (.clk_sys, .rst_n, .reset_pin_n, .sclk, .cs_n, .sdi, .sdo,
    .convert_start_select(cs_n), .conversion_done, .supply_alarm_raw, .input_alarm_raw,
    .supply_alarm, .input_alarm, .light_sleep_state, .power_down, .link_cpol, .link_cpha,
    .src_sync_mode, .sync_clock_internal, .out_mode_invalid, .dual_data_lane,
    .shared_alarm_data_pin_o, .shared_alarm_data_pin_oe);
  initial
  begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  // oldest note against the observed result
  always @(res_evt)
  begin
    cmp_count++;
    if (exp_q.size() == 0 || obs !== exp_q.pop_front())
    begin
      n_errors++;
      $display("Error at %0t: unexpected %h", $time, obs);
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic note(input logic [7:0] o, input logic [7:0] e);
    #1;
    exp_q.push_back(e);
    obs = o;
    -> res_evt;
    #1;
  endtask : note
  task automatic fr(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    adcc_host_model_inst.xfer({c, a, d});
    repeat (8) @(posedge clk_sys);
  endtask : fr
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    fr(adcc_pkg::CMD_WRITE, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    fr(adcc_pkg::CMD_READ, a, 8'h00);
    fr(8'h00, 8'h00, 8'h00);
    note(adcc_host_model_inst.rd, e);
  endtask : rd
  task automatic pin_rst;
    @(posedge clk_sys);
    reset_pin_n <= 1'h0;
    repeat (4) @(posedge clk_sys);
    reset_pin_n <= 1'h1;
    repeat (6) @(posedge clk_sys);
  endtask : pin_rst
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  initial
  begin
    {rst_n, conversion_done, supply_alarm_raw, input_alarm_raw} = 4'h0;
    reset_pin_n = 1'h1;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    for (i = 4; i < 16; i++) rd(i[7:0], 8'h00);
    $display("reset values done");
    seed = xs(seed);
    wr(adcc_pkg::ADDR_RST_PWR_B0, seed[7:0]);
    rd(adcc_pkg::ADDR_RST_PWR_B0, 8'h00);
    wr(adcc_pkg::ADDR_RST_PWR_B1, adcc_pkg::UNLOCK_VALUE);
    rd(adcc_pkg::ADDR_RST_PWR_B1, adcc_pkg::UNLOCK_VALUE);
    wr(adcc_pkg::ADDR_RST_PWR_B0, 8'hFF);
    rd(adcc_pkg::ADDR_RST_PWR_B0, 8'h37);
    {conversion_done, supply_alarm_raw, input_alarm_raw} <= 3'h7;
    repeat (4) @(posedge clk_sys);
    note(ctl_a, 8'h04);
    wr(adcc_pkg::ADDR_RST_PWR_B0, 8'h02);
    rd(adcc_pkg::ADDR_RST_PWR_B0, 8'h06);
    note(ctl_a, 8'h38);
    conversion_done <= 1'h0;
    repeat (4) @(posedge clk_sys);
    note(ctl_a, 8'h30);
    $display("key and power done");
    for (i = 0; i < 4; i++)
    begin
      wr(adcc_pkg::ADDR_OUT_CTL_B1, 8'h10 | i[7:0]);
      wr(adcc_pkg::ADDR_OUT_CTL_B0, 8'h40 | i[7:0]);
      rd(adcc_pkg::ADDR_OUT_CTL_B1, 8'h10 | i[7:0]);
      rd(adcc_pkg::ADDR_OUT_CTL_B0, 8'h40 | i[7:0]);
      note(ctl_b & ((i == 0) ? 8'hFD : 8'hFF), {2'h0, i == 3, i == 3, i == 2, i == 3,
        i == 1 || i == 2, i != 0});
    end
    $display("output control done");
    pin_rst();
    rd(adcc_pkg::ADDR_RST_PWR_B1, 8'h00);
    rd(adcc_pkg::ADDR_OUT_CTL_B0, 8'h43);
    rd(adcc_pkg::ADDR_OUT_CTL_B1, 8'h00);
    pin_rst();
    rd(adcc_pkg::ADDR_RST_PWR_B0, 8'h06);
    for (i = 3; i >= 0; i--)
    begin
      wr(adcc_pkg::ADDR_IN_PROT_B0, i[7:0]);
      adcc_host_model_inst.cpol = i[1];
      adcc_host_model_inst.cpha = i[0];
      rd(adcc_pkg::ADDR_IN_PROT_B0, i[7:0]);
      note(ctl_a & 8'h03, i[7:0]);
    end
    $display("application reset and protocol done");
    rst_n <= 1'h0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'h1;
    rd(adcc_pkg::ADDR_RST_PWR_B0, 8'h00);
    wr(adcc_pkg::ADDR_OUT_CTL_B0, 8'h03);
    pin_rst();
    rd(adcc_pkg::ADDR_OUT_CTL_B0, 8'h00);
    $display("power-on class done");
    end_of_test();
  end
endmodule : adcc_cfg_tb_top
